/* File: rtl/psi_pkg.sv */
package psi_pkg;

    // Opcodes of the string port-input family
    localparam logic [7:0]  OPC_BYTE_INPUT = 8'h6c;
    localparam logic [7:0]  OPC_WIDE_INPUT = 8'h6d;

    // Element sizes in bytes, also the index step
    localparam logic [2:0]  SIZE_BYTE      = 3'h1;
    localparam logic [2:0]  SIZE_WORD      = 3'h2;
    localparam logic [2:0]  SIZE_DWORD     = 3'h4;

    localparam logic [1:0]  PRIV_USER      = 2'h3;
    localparam logic [31:0] ERR_CODE_ZERO  = 32'h0;
    localparam logic [31:0] COUNT_ZERO     = 32'h0;

    localparam int          PORT_ADDR_W    = 16;
    localparam int          DATA_W         = 32;
    localparam int          LANES          = 4;

    typedef enum logic [2:0]
    {
        FLT_NONE,
        FLT_GP,
        FLT_SS,
        FLT_PF,
        FLT_AC
    } psi_fault_e;

    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_CHECK,
        ST_PERM,
        ST_DEST,
        ST_IO,
        ST_MEM,
        ST_STEP
    } psi_state_e;

endpackage

/* File: rtl/psi_io_perm_check.sv */
`timescale 1ns/1ps
module psi_io_perm_check
(
    input  wire logic       protectionEnable,
    input  wire logic       v86Flag,
    input  wire logic [1:0] currentPrivilege,
    input  wire logic [1:0] ioPrivilegeLevel,
    input  wire logic [2:0] elemSize,
    input  wire logic [3:0] permBits,
    output logic            needCheck,
    output logic            permFault
);
    import psi_pkg::*;

    logic [LANES-1:0] coverMask;

    // One permission bit per byte of the accessed port range
    for (genvar i = 0; i < LANES; i++)
    begin : g_cover
        assign coverMask[i] = (3'(i) < elemSize);
    end

    // In v86 mode the privilege level does not excuse the check
    assign needCheck = protectionEnable && (v86Flag || (currentPrivilege > ioPrivilegeLevel));
    assign permFault = needCheck && (|(permBits & coverMask));

endmodule // psi_io_perm_check

/* File: rtl/psi_dest_check.sv */
`timescale 1ns/1ps
module psi_dest_check
(
    input  wire logic                 protectionEnable,
    input  wire logic                 v86Flag,
    input  wire logic [1:0]           currentPrivilege,
    input  wire logic                 alignCheckEnable,
    input  wire logic                 segWritable,
    input  wire logic                 segNull,
    input  wire logic [31:0]          segLimit,
    input  wire logic [31:0]          stackSegLimit,
    input  wire logic [31:0]          offset,
    input  wire logic [2:0]           elemSize,
    output psi_pkg::psi_fault_e       destFault
);
    import psi_pkg::*;

    logic [32:0] lastByte;
    logic        overSeg;
    logic        overStack;
    logic        unaligned;
    logic        protMode;

    assign lastByte  = {1'b0, offset} + {30'h0, elemSize} - 33'h1;
    assign overSeg   = lastByte > {1'b0, segLimit};
    assign overStack = lastByte > {1'b0, stackSegLimit};
    assign unaligned = |(offset[2:0] & (elemSize - 3'h1));
    assign protMode  = protectionEnable && !v86Flag;

    // Limit and writability faults take priority over alignment
    always_comb
    begin
        destFault = FLT_NONE;
        if (!protectionEnable)
        begin
            if (overSeg)
                destFault = FLT_GP;
            else if (overStack)
                destFault = FLT_SS;
        end
        else if (protMode && !segWritable)
            destFault = FLT_GP;
        else if ((protMode && segNull) || overSeg)
            destFault = FLT_GP;
        else if (alignCheckEnable && unaligned && (v86Flag || currentPrivilege == PRIV_USER))
            destFault = FLT_AC;
    end

endmodule // psi_dest_check

/* File: rtl/psi_exec.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - 6C byte form, 6D word or dword
// - Port number only from 16-bit port register
// - Byte size by opcode, wider by operand size
// - Store at extra segment, 16/32-bit index
// - Destination segment always extra, overrides ignored
// - Direction flag 0 increments, 1 decrements
// - Step by 1, 2 or 4
// - Read and store before index update
// - Repeat prefix loops count register elements
// - Permission bitmap consulted when privilege insufficient
// - Set permission bit gives GP zero, no transfer
// - V86 mode always checks bitmap, any level
// - Nonwritable destination segment gives GP zero in protected mode outside v86
// - Illegal extra segment address gives GP
// - Unaligned user access with checking gives AC
// - Real mode stack limit overrun gives SS
// - Failed page translation gives page fault
module psi_exec
#(
    parameter int PORT_W = 16,
    parameter int IDX_W  = 32
)
(
    input  wire logic                 clock,
    input  wire logic                 rst,
    // Instruction start
    input  wire logic                 start,
    input  wire logic [7:0]           opcode,
    input  wire logic                 opSize32,
    input  wire logic                 repPrefix,
    input  wire logic [31:0]          destIndexIn,
    input  wire logic [31:0]          repeatCountIn,
    input  wire logic [15:0]          portAddressReg,
    input  wire logic                 directionFlag,
    // Mode and privilege
    input  wire logic                 protectionEnable,
    input  wire logic                 v86Flag,
    input  wire logic [1:0]           currentPrivilege,
    input  wire logic [1:0]           ioPrivilegeLevel,
    input  wire logic                 alignCheckEnable,
    // Extra segment and stack segment state
    input  wire logic                 segWritable,
    input  wire logic                 segNull,
    input  wire logic [31:0]          segLimit,
    input  wire logic [31:0]          stackSegLimit,
    // Permission bitmap lookup
    output logic                      permReq,
    input  wire logic                 permValid,
    input  wire logic [3:0]           permBits,
    // Port read
    output logic                      ioReq,
    output logic [15:0]               ioPort,
    output logic [2:0]                ioSize,
    input  wire logic                 ioAck,
    input  wire logic [31:0]          ioData,
    // Memory store
    output logic                      memReq,
    output logic [31:0]               memAddr,
    output logic [31:0]               memData,
    output logic [2:0]                memSize,
    input  wire logic                 memAck,
    input  wire logic                 memPageFault,
    input  wire logic [31:0]          memFaultCode,
    // Completion
    output logic                      busy,
    output logic                      done,
    output logic                      faultValid,
    output psi_pkg::psi_fault_e       faultKind,
    output logic [31:0]               faultCode,
    output logic [31:0]               destIndexOut,
    output logic [31:0]               repeatCountOut
);
    import psi_pkg::*;

    if (PORT_W != PORT_ADDR_W || IDX_W != DATA_W)
    begin : g_bad_param
        $error("psi_exec supports only a 16-bit port and 32-bit index");
    end

    // Lane masks assume one byte lane per data byte
    if (DATA_W != 8 * LANES)
    begin : g_bad_lanes
        $error("psi_exec needs one byte lane per data byte");
    end

    // The widest element must fit the permission and lane masks
    if (int'(SIZE_DWORD) != LANES)
    begin : g_bad_size
        $error("psi_exec needs the doubleword size to match the lane count");
    end

    typedef struct packed
    {
        psi_state_e  fsm;
        logic [2:0]  elemSize;
        logic        wide;
        logic        block_loop_prefix;
        logic        df;
        logic [15:0] port;
        logic [31:0] idx;
        logic [31:0] cnt;
        logic        busy;
        logic        permReq;
        logic        ioReq;
        logic        memReq;
        logic [31:0] memAddr;
        logic [31:0] memData;
        logic        done;
        logic        faultValid;
        psi_fault_e  faultKind;
        logic [31:0] faultCode;
    } psi_exec_state_s;

    psi_exec_state_s s;
    psi_exec_state_s next_s;

    logic             validOpcode;
    logic [2:0]       startSize;
    logic [31:0]      effOffset;
    logic [31:0]      stepAmt;
    logic [31:0]      idxStepped;
    logic [31:0]      nextIdx;
    logic [31:0]      cntLess;
    logic [DATA_W-1:0] laneMask;
    logic             needPermCheck;
    logic             permFault;
    psi_fault_e       destFault;

    assign validOpcode = (opcode == OPC_BYTE_INPUT) || (opcode == OPC_WIDE_INPUT);

    // Size is fixed by the opcode for bytes, by operand size otherwise
    always_comb
    begin
        case (opcode)
            OPC_BYTE_INPUT: startSize = SIZE_BYTE;
            OPC_WIDE_INPUT: startSize = opSize32 ? SIZE_DWORD : SIZE_WORD;
            default:        startSize = SIZE_BYTE;
        endcase
    end

    // Narrow index addresses only its low half; upper bits are kept
    assign effOffset  = s.wide ? s.idx : {16'h0, s.idx[15:0]};
    assign stepAmt    = {29'h0, s.elemSize};
    assign idxStepped = s.df ? (s.idx - stepAmt) : (s.idx + stepAmt);
    assign nextIdx    = s.wide ? idxStepped : {s.idx[31:16], idxStepped[15:0]};
    assign cntLess    = s.cnt - 32'h1;

    // Only the lanes of the element reach memory, the rest read zero
    for (genvar i = 0; i < LANES; i++)
    begin : g_lane
        assign laneMask[8*i +: 8] = {8{3'(i) < s.elemSize}};
    end

    psi_io_perm_check u_perm
    (
        .protectionEnable (protectionEnable),
        .v86Flag          (v86Flag),
        .currentPrivilege (currentPrivilege),
        .ioPrivilegeLevel (ioPrivilegeLevel),
        .elemSize         (s.elemSize),
        .permBits         (permBits),
        .needCheck        (needPermCheck),
        .permFault        (permFault)
    );

    psi_dest_check u_dest
    (
        .protectionEnable (protectionEnable),
        .v86Flag          (v86Flag),
        .currentPrivilege (currentPrivilege),
        .alignCheckEnable (alignCheckEnable),
        .segWritable      (segWritable),
        .segNull          (segNull),
        .segLimit         (segLimit),
        .stackSegLimit    (stackSegLimit),
        .offset           (effOffset),
        .elemSize         (s.elemSize),
        .destFault        (destFault)
    );

    always_comb
    begin
        next_s            = s;
        next_s.done       = 1'b0;
        next_s.faultValid = 1'b0;
        case (s.fsm)
            ST_IDLE:
            begin
                if (start && validOpcode)
                begin
                    next_s.elemSize  = startSize;
                    next_s.wide      = opSize32;
                    next_s.block_loop_prefix       = repPrefix;
                    next_s.df        = directionFlag;
                    next_s.port      = portAddressReg;
                    next_s.idx       = destIndexIn;
                    next_s.cnt       = repeatCountIn;
                    next_s.faultKind = FLT_NONE;
                    next_s.faultCode = ERR_CODE_ZERO;
                    // Zero count ends at once and busy never rises
                    if (repPrefix && repeatCountIn == COUNT_ZERO)
                        next_s.done = 1'b1;
                    else
                    begin
                        next_s.busy = 1'b1;
                        next_s.fsm  = ST_CHECK;
                    end
                end
            end
            ST_CHECK:
            begin
                if (needPermCheck)
                begin
                    next_s.permReq = 1'b1;
                    next_s.fsm     = ST_PERM;
                end
                else
                    next_s.fsm = ST_DEST;
            end
            ST_PERM:
            begin
                if (permValid)
                begin
                    next_s.permReq = 1'b0;
                    if (permFault)
                    begin
                        // Aborts before any port read
                        next_s.fsm        = ST_IDLE;
                        next_s.busy       = 1'b0;
                        next_s.faultValid = 1'b1;
                        next_s.faultKind  = FLT_GP;
                        next_s.faultCode  = ERR_CODE_ZERO;
                    end
                    else
                        next_s.fsm = ST_DEST;
                end
            end
            ST_DEST:
            begin
                // Checked before the read so a segment or alignment fault never drains a port
                if (destFault != FLT_NONE)
                begin
                    next_s.fsm        = ST_IDLE;
                    next_s.busy       = 1'b0;
                    next_s.faultValid = 1'b1;
                    next_s.faultKind  = destFault;
                    next_s.faultCode  = ERR_CODE_ZERO;
                end
                else
                begin
                    next_s.ioReq = 1'b1;
                    next_s.fsm   = ST_IO;
                end
            end
            ST_IO:
            begin
                if (ioAck)
                begin
                    next_s.ioReq   = 1'b0;
                    next_s.memReq  = 1'b1;
                    next_s.memAddr = effOffset;
                    next_s.memData = ioData & laneMask;
                    next_s.fsm     = ST_MEM;
                end
            end
            ST_MEM:
            begin
                if (memAck)
                begin
                    next_s.memReq = 1'b0;
                    if (memPageFault)
                    begin
                        next_s.fsm        = ST_IDLE;
                        next_s.busy       = 1'b0;
                        next_s.faultValid = 1'b1;
                        next_s.faultKind  = FLT_PF;
                        next_s.faultCode  = memFaultCode;
                    end
                    else
                        next_s.fsm = ST_STEP;
                end
            end
            ST_STEP:
            begin
                // Index moves only after a clean store
                next_s.idx = nextIdx;
                if (s.block_loop_prefix)
                begin
                    next_s.cnt = cntLess;
                    if (cntLess == COUNT_ZERO)
                    begin
                        next_s.fsm  = ST_IDLE;
                        next_s.busy = 1'b0;
                        next_s.done = 1'b1;
                    end
                    else
                        next_s.fsm = ST_CHECK;
                end
                else
                begin
                    next_s.fsm  = ST_IDLE;
                    next_s.busy = 1'b0;
                    next_s.done = 1'b1;
                end
            end
            default:
            begin
                next_s = '0;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign permReq        = s.permReq;
    assign ioReq          = s.ioReq;
    assign ioPort         = s.port;
    assign ioSize         = s.elemSize;
    assign memReq         = s.memReq;
    assign memAddr        = s.memAddr;
    assign memData        = s.memData;
    assign memSize        = s.elemSize;
    assign busy           = s.busy;
    assign done           = s.done;
    assign faultValid     = s.faultValid;
    assign faultKind      = s.faultKind;
    assign faultCode      = s.faultCode;
    assign destIndexOut   = s.idx;
    assign repeatCountOut = s.cnt;

endmodule // psi_exec

/* File: dv/psi_exec_sva.sv */
`timescale 1ns/1ps
module psi_exec_sva
    import psi_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        permReq,
    input wire logic        permValid,
    input wire logic [3:0]  permBits,
    input wire logic        ioReq,
    input wire logic [15:0] ioPort,
    input wire logic [2:0]  ioSize,
    input wire logic        ioAck,
    input wire logic        memReq,
    input wire logic [31:0] memAddr,
    input wire logic        memAck,
    input wire logic        memPageFault,
    input wire logic [31:0] memFaultCode,
    input wire logic        busy,
    input wire logic        done,
    input wire logic        faultValid,
    input wire psi_fault_e  faultKind,
    input wire logic [31:0] faultCode,
    input wire logic [31:0] destIndexOut
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    logic [31:0] pfCode;

    // Code is gone from the pins once the ack pulse ends
    always_ff @(posedge clock)
    begin
        if (memReq && memAck)
            pfCode <= memFaultCode;
    end

    // Only bits inside the element size count
    sequence s_permDeny;
        permReq && permValid && ((permBits & ((4'h1 << ioSize) - 4'h1)) != 4'h0);
    endsequence
    sequence s_ioDone;
        ioReq && ioAck;
    endsequence

    property p_ioHold;
        ioReq && !ioAck |=> ioReq && $stable(ioPort) && $stable(ioSize);
    endproperty
    a_ioHold: assert property (p_ioHold) else $error("port read dropped");
    property p_storeAfterRead;
        s_ioDone |=> memReq && !ioReq;
    endproperty
    a_storeAfterRead: assert property (p_storeAfterRead) else $error("no store after read");
    property p_memHold;
        memReq && !memAck |=> memReq && $stable(memAddr);
    endproperty
    a_memHold: assert property (p_memHold) else $error("store dropped");
    property p_denyNoXfer;
        s_permDeny |=> (!ioReq && !memReq)[*3];
    endproperty
    a_denyNoXfer: assert property (p_denyNoXfer) else $error("transfer after deny");
    property p_denyCode;
        s_permDeny |-> ##[1:3] (faultValid && faultKind == FLT_GP && faultCode == ERR_CODE_ZERO);
    endproperty
    a_denyCode: assert property (p_denyCode) else $error("deny fault missing");
    property p_pageFault;
        memReq && memAck && memPageFault |->
            ##[1:3] (faultValid && faultKind == FLT_PF && faultCode == pfCode);
    endproperty
    a_pageFault: assert property (p_pageFault) else $error("page fault missing");
    property p_faultKeepsIdx;
        faultValid |-> $stable(destIndexOut);
    endproperty
    a_faultKeepsIdx: assert property (p_faultKeepsIdx) else $error("index moved on fault");
    property p_busyEnd;
        // A reset in flight drops busy with no end pulse
        $fell(busy) && !$past(rst) |-> done || faultValid;
    endproperty
    a_busyEnd: assert property (p_busyEnd) else $error("busy ended silently");
endmodule // psi_exec_sva

/* File: dv/psi_port_mem_model.sv */
`timescale 1ns/1ps
module psi_port_mem_model
(
    input  wire logic        clock,
    input  wire logic        permReq,
    input  wire logic        ioReq,
    input  wire logic [15:0] ioPort,
    input  wire logic [2:0]  ioSize,
    input  wire logic        memReq,
    input  wire logic [31:0] memAddr,
    input  wire logic [31:0] memData,
    input  wire logic [2:0]  memSize,
    output logic             permValid,
    output logic [3:0]       permBits,
    output logic             ioAck,
    output logic [31:0]      ioData,
    output logic             memAck,
    output logic             memPageFault,
    output logic [31:0]      memFaultCode
);
    localparam logic [31:0] PORT_VALUE = 32'h84217e3c;
    localparam logic [31:0] FAULT_CODE = 32'h7;

    logic [3:0]  denyBits    = 4'h0;
    logic        pageFaultOn = 1'b0;
    logic [15:0] lastPort    = 16'h0;
    logic [31:0] lastData    = 32'h0;
    logic [31:0] lastAddr    = 32'h0;
    logic [2:0]  ioSz        = 3'h0;
    logic [2:0]  memSz       = 3'h0;
    int          dly         = 0;
    int          nWr         = 0;
    int          cnt         = 0;

    // Inverted outside the pulse so a late sample cannot match
    assign permBits     = permValid ? denyBits : ~denyBits;
    assign ioData       = ioAck ? PORT_VALUE : ~PORT_VALUE;
    assign memPageFault = memAck ? pageFaultOn : ~pageFaultOn;
    assign memFaultCode = memAck ? FAULT_CODE : ~FAULT_CODE;

    // Requests seen one edge late, so even a prompt answer costs a cycle
    always @(posedge clock)
    begin
        permValid <= 1'b0;
        ioAck     <= 1'b0;
        memAck    <= 1'b0;
        if (permValid || ioAck || memAck || !(permReq || ioReq || memReq))
            cnt <= 0;
        else if (cnt < dly)
            cnt <= cnt + 1;
        else
        begin
            permValid <= permReq;
            ioAck     <= ioReq;
            memAck    <= memReq;
            if (ioReq)
            begin
                lastPort <= ioPort;
                ioSz     <= ioSize;
            end
            if (memReq && !pageFaultOn)
            begin
                lastData <= memData;
                lastAddr <= memAddr;
                memSz    <= memSize;
                nWr      <= nWr + 1;
            end
        end
    end
endmodule // psi_port_mem_model

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
    import psi_pkg::*;

    logic        clock = 1'b0;
    logic        rst, start, opSize32, repPrefix, directionFlag, protectionEnable, v86Flag;
    logic        alignCheckEnable, segWritable, segNull, permReq, permValid, ioReq, ioAck;
    logic        memReq, memAck, memPageFault, busy, done, faultValid;
    logic [1:0]  currentPrivilege, ioPrivilegeLevel;
    logic [2:0]  ioSize, memSize;
    logic [3:0]  permBits;
    logic [7:0]  opcode;
    logic [15:0] portAddressReg, ioPort;
    logic [31:0] destIndexIn, repeatCountIn, segLimit, stackSegLimit, ioData, memAddr, memData;
    logic [31:0] memFaultCode, faultCode, destIndexOut, repeatCountOut;
    psi_fault_e  faultKind;
    int          fails = 0;
    int          num_checks = 0;

    always #20 clock = ~clock;

    psi_exec i_dut
    (
        .clock, .rst, .start, .opcode, .opSize32, .repPrefix, .destIndexIn, .repeatCountIn,
        .portAddressReg, .directionFlag, .protectionEnable, .v86Flag, .currentPrivilege,
        .ioPrivilegeLevel, .alignCheckEnable, .segWritable, .segNull, .segLimit, .stackSegLimit,
        .permReq, .permValid, .permBits, .ioReq, .ioPort, .ioSize, .ioAck, .ioData, .memReq,
        .memAddr, .memData, .memSize, .memAck, .memPageFault, .memFaultCode, .busy, .done,
        .faultValid, .faultKind, .faultCode, .destIndexOut, .repeatCountOut
    );

    psi_port_mem_model i_model
    (
        .clock, .permReq, .ioReq, .ioPort, .ioSize, .memReq, .memAddr, .memData, .memSize,
        .permValid, .permBits, .ioAck, .ioData, .memAck, .memPageFault, .memFaultCode
    );

    task automatic chk(input string what, input logic [31:0] exp, got);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("Checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // m = {protection, v86, align check, writable}
    task automatic mode(input logic [3:0] m, input logic [1:0] current_privilege, io_privilege_level,
                        input logic [31:0] lim, slim);
        {protectionEnable, v86Flag, alignCheckEnable, segWritable} = m;
        currentPrivilege = current_privilege;
        ioPrivilegeLevel = io_privilege_level;
        segLimit = lim;
        stackSegLimit = slim;
    endtask

    // f = {32-bit operand, repeat, direction}
    task automatic run(input logic [7:0] opc, input logic [2:0] f, input logic [31:0] idx, cnt,
                       input psi_fault_e kind, input logic [31:0] eIdx, eCnt, input int eWr);
        int n;
        int w0;
        w0 = i_model.nWr;
        opcode = opc;
        {opSize32, repPrefix, directionFlag} = f;
        destIndexIn = idx;
        repeatCountIn = cnt;
        start = 1'b1;
        @(posedge clock);
        #2;
        start = 1'b0;
        for (n = 0; n < 300 && done !== 1'b1 && faultValid !== 1'b1; n++)
        begin
            @(posedge clock);
            #2;
        end
        chk("end pulse", 32'h1, {31'h0, done | faultValid});
        chk("fault kind", kind, faultKind);
        chk("dest index", eIdx, destIndexOut);
        chk("count", eCnt, repeatCountOut);
        chk("stores", eWr, i_model.nWr - w0);
        @(posedge clock);
        #2;
    endtask

    initial
    begin
        #400000;
        fails++;
        test_done();
    end

    initial
    begin
        rst = 1'b1;
        start = 1'b0;
        opcode = 8'h0;
        {opSize32, repPrefix, directionFlag} = 3'h0;
        destIndexIn = 32'h0;
        repeatCountIn = 32'h0;
        portAddressReg = 16'hfffe;
        segNull = 1'b0;
        mode(4'h1, 2'h0, 2'h0, 32'hffffffff, 32'hffffffff);
        repeat (4) @(posedge clock);
        #2;
        rst = 1'b0;
        run(OPC_BYTE_INPUT, 3'h0, 32'h100, 32'h5, FLT_NONE, 32'h101, 32'h5, 1);
        chk("port", 32'hfffe, {16'h0, i_model.lastPort});
        chk("byte lane", 32'h3c, i_model.lastData);
        chk("dest addr", 32'h100, i_model.lastAddr);
        chk("byte sizes", 32'h9, {26'h0, i_model.ioSz, i_model.memSz});
        run(OPC_WIDE_INPUT, 3'h4, 32'h200, 32'h0, FLT_NONE, 32'h204, 32'h0, 1);
        chk("dword lane", 32'h84217e3c, i_model.lastData);
        chk("dword sizes", 32'h24, {26'h0, i_model.ioSz, i_model.memSz});
        run(OPC_WIDE_INPUT, 3'h1, 32'h12340000, 32'h0, FLT_NONE, 32'h1234fffe, 32'h0, 1);
        chk("word lane", 32'h7e3c, i_model.lastData);
        chk("word addr", 32'h0, i_model.lastAddr);
        chk("word sizes", 32'h12, {26'h0, i_model.ioSz, i_model.memSz});
        i_model.dly = 3;
        run(OPC_BYTE_INPUT, 3'h3, 32'h300, 32'h3, FLT_NONE, 32'h2fd, 32'h0, 3);
        chk("last addr", 32'h2fe, i_model.lastAddr);
        run(OPC_BYTE_INPUT, 3'h2, 32'h400, 32'h0, FLT_NONE, 32'h400, 32'h0, 0);
        i_model.dly = 0;
        mode(4'h9, 2'h3, 2'h0, 32'hffffffff, 32'hffffffff);
        i_model.denyBits = 4'h1;
        run(OPC_BYTE_INPUT, 3'h0, 32'h500, 32'h0, FLT_GP, 32'h500, 32'h0, 0);
        chk("error code", 32'h0, faultCode);
        i_model.denyBits = 4'h2;
        run(OPC_BYTE_INPUT, 3'h4, 32'h500, 32'h0, FLT_NONE, 32'h501, 32'h0, 1);
        chk("wide byte sizes", 32'h9, {26'h0, i_model.ioSz, i_model.memSz});
        mode(4'hd, 2'h0, 2'h3, 32'hffffffff, 32'hffffffff);
        i_model.denyBits = 4'h8;
        run(OPC_WIDE_INPUT, 3'h4, 32'h600, 32'h0, FLT_GP, 32'h600, 32'h0, 0);
        i_model.denyBits = 4'h0;
        mode(4'h8, 2'h0, 2'h0, 32'hffffffff, 32'hffffffff);
        run(OPC_BYTE_INPUT, 3'h0, 32'h700, 32'h0, FLT_GP, 32'h700, 32'h0, 0);
        mode(4'h9, 2'h0, 2'h0, 32'hff, 32'hffffffff);
        run(OPC_BYTE_INPUT, 3'h0, 32'h100, 32'h0, FLT_GP, 32'h100, 32'h0, 0);
        mode(4'hb, 2'h3, 2'h3, 32'hffffffff, 32'hffffffff);
        run(OPC_WIDE_INPUT, 3'h0, 32'h101, 32'h0, FLT_AC, 32'h101, 32'h0, 0);
        mode(4'h1, 2'h0, 2'h0, 32'hffffffff, 32'hff);
        run(OPC_BYTE_INPUT, 3'h0, 32'h1000, 32'h0, FLT_SS, 32'h1000, 32'h0, 0);
        mode(4'h9, 2'h0, 2'h0, 32'hffffffff, 32'hffffffff);
        i_model.pageFaultOn = 1'b1;
        run(OPC_BYTE_INPUT, 3'h0, 32'h800, 32'h0, FLT_PF, 32'h800, 32'h0, 0);
        chk("pf code", 32'h7, faultCode);
        opcode = 8'h6e;
        start = 1'b1;
        @(posedge clock);
        #2;
        start = 1'b0;
        chk("ignored", 32'h0, {31'h0, busy | done});
        // Reset in flight must clear the element in progress
        opcode = OPC_BYTE_INPUT;
        start = 1'b1;
        @(posedge clock);
        #2;
        start = 1'b0;
        rst = 1'b1;
        @(posedge clock);
        #2;
        rst = 1'b0;
        @(posedge clock);
        #2;
        chk("reset busy", 32'h0, {29'h0, busy, ioReq, permReq});
        chk("reset index", 32'h0, destIndexOut);
        test_done();
    end
endmodule // tb

bind psi_exec psi_exec_sva i_sva
(
    .clock, .rst, .permReq, .permValid, .permBits, .ioReq, .ioPort, .ioSize, .ioAck, .memReq,
    .memAddr, .memAck, .memPageFault, .memFaultCode, .busy, .done, .faultValid, .faultKind,
    .faultCode, .destIndexOut
);
